// ==== logic/i2iv_pkg.sv ====
// Constants, field layouts and carrier types for the interrupt view and master control block
`default_nettype none
package i2iv_pkg;

  // Register byte addresses on the 12-bit AXI4-Lite window
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] ADDR_MASKED_VIEW    = 12'h818;
  localparam logic [11:0] ADDR_MASTER_CONTROL = 12'h820;
  localparam int unsigned WORD_LSB            = 2;

  // Masked interrupt view bit positions
  localparam int unsigned VIEW_MASTER_PENDING   = 0;
  localparam int unsigned VIEW_MASTER_ARB_LOST  = 4;
  localparam int unsigned VIEW_MASTER_SS_ERROR  = 6;
  localparam int unsigned VIEW_TARGET_PENDING   = 8;
  localparam int unsigned VIEW_TARGET_NOT_STR   = 11;
  localparam int unsigned VIEW_TARGET_DESEL     = 15;
  localparam int unsigned VIEW_WATCH_READY      = 16;
  localparam int unsigned VIEW_WATCH_OVERFLOW   = 17;
  localparam int unsigned VIEW_WATCH_IDLE       = 19;
  localparam int unsigned VIEW_EVENT_GAP_TO     = 24;
  localparam int unsigned VIEW_CLOCK_LOW_TO     = 25;

  // Master control bit positions
  localparam int unsigned CTL_PROCEED    = 0;
  localparam int unsigned CTL_BEGIN      = 1;
  localparam int unsigned CTL_END        = 2;
  localparam int unsigned CTL_DMA_ENABLE = 3;

  // Reset values and bus answers
  localparam logic        DMA_ENABLE_RESET = 1'h0;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic master_pending;
    logic master_arbitration_lost;
    logic master_start_stop_error;
    logic target_pending;
    logic target_not_stretching;
    logic target_deselected;
    logic bus_watch_ready;
    logic bus_watch_overflow;
    logic bus_watch_idle;
    logic event_gap_timeout;
    logic clock_low_timeout;
  } i2iv_flags_t;

  typedef struct packed {
    logic master_proceed;
    logic master_begin_cmd;
    logic master_end_cmd;
  } i2iv_cmd_t;

  localparam i2iv_cmd_t CMD_NONE = '{1'h0, 1'h0, 1'h0};

endpackage : i2iv_pkg
`default_nettype wire

// ==== logic/i2iv_cmd_cross.sv ====
// Toggle handshake that carries master commands from the register clock to the link clock
`timescale 1ns/1ns
`default_nettype none
module i2iv_cmd_cross (
  input  wire logic              src_clock_i,
  input  wire logic              src_rst_i,
  input  wire logic              src_valid_i,
  input  wire i2iv_pkg::i2iv_cmd_t src_cmd_i,
  output logic                   src_busy_o,
  input  wire logic              dst_clock_i,
  input  wire logic              dst_rst_i,
  output logic                   dst_valid_o,
  output var i2iv_pkg::i2iv_cmd_t dst_cmd_o
);

  logic                req_tgl;
  i2iv_pkg::i2iv_cmd_t held_cmd;
  logic                ack_meta;
  logic                ack_sync;
  logic                req_meta;
  logic                req_sync;
  logic                req_last;
  logic                ack_tgl;

  // Held command stays frozen while busy, so the far side may sample it as a word
  assign src_busy_o = req_tgl ^ ack_sync;

  always_ff @(posedge src_clock_i) begin
    if (src_rst_i) begin
      req_tgl  <= 1'h0;
      held_cmd <= i2iv_pkg::CMD_NONE;
    end else if (src_valid_i && !src_busy_o) begin
      req_tgl  <= ~req_tgl;
      held_cmd <= src_cmd_i;
    end
  end

  always_ff @(posedge src_clock_i) begin
    if (src_rst_i) begin
      ack_meta <= 1'h0;
      ack_sync <= 1'h0;
    end else begin
      ack_meta <= ack_tgl;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge dst_clock_i) begin
    if (dst_rst_i) begin
      req_meta <= 1'h0;
      req_sync <= 1'h0;
      req_last <= 1'h0;
    end else begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_last <= req_sync;
    end
  end

  always_ff @(posedge dst_clock_i) begin
    if (dst_rst_i) begin
      ack_tgl     <= 1'h0;
      dst_valid_o <= 1'h0;
      dst_cmd_o   <= i2iv_pkg::CMD_NONE;
    end else begin
      dst_valid_o <= req_sync ^ req_last;
      if (req_sync ^ req_last) begin
        dst_cmd_o <= held_cmd;
        ack_tgl   <= req_sync;
      end
    end
  end

endmodule : i2iv_cmd_cross
`default_nettype wire

// ==== logic/i2iv_view_ctl.sv ====
// Masked interrupt view and master control register with AXI4-Lite access and link-side commands
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module i2iv_view_ctl (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // AXI4-Lite slave
  input  wire logic [11:0]          s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [11:0]          s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  // Raw status flags and enables from the flag logic, same clock
  input  wire i2iv_pkg::i2iv_flags_t status_raw_i,
  input  wire i2iv_pkg::i2iv_flags_t int_enable_i,
  output logic                      dma_enable_o,
  output logic                      cmd_in_flight_o,
  // Link side, on the link clock
  input  wire logic                 link_clock_i,
  input  wire logic                 link_receiving_i,
  input  wire logic                 link_data_phase_i,
  output logic                      link_proceed_o,
  output logic                      link_begin_o,
  output logic                      link_end_o,
  output logic                      link_end_nack_o,
  output logic                      link_dma_req_o,
  output logic                      link_auto_ack_o
);

  // Word-aligned address match, shared by the read and write decoders
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] target);
    addr_is = (addr[11:i2iv_pkg::WORD_LSB] == target[11:i2iv_pkg::WORD_LSB]);
  endfunction : addr_is

  // Scatter the flag struct onto the view layout; unused positions read zero
  function automatic logic [31:0] place_flags(input i2iv_pkg::i2iv_flags_t f);
    logic [31:0] w;
    w = i2iv_pkg::ZERO_WORD;
    w[i2iv_pkg::VIEW_MASTER_PENDING] = f.master_pending;
    w[i2iv_pkg::VIEW_MASTER_ARB_LOST] = f.master_arbitration_lost;
    w[i2iv_pkg::VIEW_MASTER_SS_ERROR] = f.master_start_stop_error;
    w[i2iv_pkg::VIEW_TARGET_PENDING] = f.target_pending;
    w[i2iv_pkg::VIEW_TARGET_NOT_STR] = f.target_not_stretching;
    w[i2iv_pkg::VIEW_TARGET_DESEL] = f.target_deselected;
    w[i2iv_pkg::VIEW_WATCH_READY] = f.bus_watch_ready;
    w[i2iv_pkg::VIEW_WATCH_OVERFLOW] = f.bus_watch_overflow;
    w[i2iv_pkg::VIEW_WATCH_IDLE] = f.bus_watch_idle;
    w[i2iv_pkg::VIEW_EVENT_GAP_TO] = f.event_gap_timeout;
    w[i2iv_pkg::VIEW_CLOCK_LOW_TO] = f.clock_low_timeout;
    place_flags = w;
  endfunction : place_flags

  // ---------------- Write channel ----------------
  logic        aw_held;
  logic [11:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_fire;
  logic        w_fire;
  logic        do_write;
  logic        wr_ctl;
  logic        wr_view;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign aw_fire         = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire          = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write        = aw_held && w_held;
  assign wr_ctl          = do_write && addr_is(aw_addr, i2iv_pkg::ADDR_MASTER_CONTROL);
  assign wr_view         = do_write && addr_is(aw_addr, i2iv_pkg::ADDR_MASKED_VIEW);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'h0;
      aw_addr <= 12'h000;
    end else if (aw_fire) begin
      aw_held <= 1'h1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held <= 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_held <= 1'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (w_fire) begin
      w_held <= 1'h1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held <= 1'h0;
    end
  end

  // A write to the view is accepted with OKAY and changes nothing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'h0;
      s_axi_bresp_o  <= i2iv_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'h1;
      s_axi_bresp_o  <= (wr_ctl || wr_view) ? i2iv_pkg::RESP_OKAY
                                            : i2iv_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'h0;
    end
  end

  // ---------------- Master control ----------------
  // Only byte lane 0 holds live bits; other lanes are reserved
  logic      ctl_lane0;
  i2iv_pkg::i2iv_cmd_t new_cmd;
  i2iv_pkg::i2iv_cmd_t cmd_pend;
  logic      cmd_busy;
  logic      cmd_launch;

  assign ctl_lane0 = wr_ctl && w_strb[0];
  assign new_cmd.master_proceed   = ctl_lane0 && w_data[i2iv_pkg::CTL_PROCEED];
  assign new_cmd.master_begin_cmd = ctl_lane0 && w_data[i2iv_pkg::CTL_BEGIN];
  assign new_cmd.master_end_cmd   = ctl_lane0 && w_data[i2iv_pkg::CTL_END];
  assign cmd_launch = (cmd_pend != i2iv_pkg::CMD_NONE) && !cmd_busy;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dma_enable_o <= i2iv_pkg::DMA_ENABLE_RESET;
    end else if (ctl_lane0) begin
      dma_enable_o <= w_data[i2iv_pkg::CTL_DMA_ENABLE];
    end
  end

  // Command bits are one-shot: they wait here until the crossing is free.
  // A write landing in the launch cycle is kept, never dropped.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_pend <= i2iv_pkg::CMD_NONE;
    end else if (cmd_launch) begin
      cmd_pend <= new_cmd;
    end else begin
      cmd_pend <= cmd_pend | new_cmd;
    end
  end

  assign cmd_in_flight_o = cmd_busy || (cmd_pend != i2iv_pkg::CMD_NONE);

  // ---------------- Read channel ----------------
  logic [31:0] view_word;
  logic [31:0] ctl_word;

  always_comb begin
    view_word = place_flags(status_raw_i & int_enable_i);
    ctl_word  = i2iv_pkg::ZERO_WORD;
    ctl_word[i2iv_pkg::CTL_DMA_ENABLE] = dma_enable_o;
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  // Reads only sample the flags, so no flag ever moves on a read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'h0;
      s_axi_rdata_o  <= i2iv_pkg::ZERO_WORD;
      s_axi_rresp_o  <= i2iv_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'h1;
      if (addr_is(s_axi_araddr_i, i2iv_pkg::ADDR_MASKED_VIEW)) begin
        s_axi_rdata_o <= view_word;
        s_axi_rresp_o <= i2iv_pkg::RESP_OKAY;
      end else if (addr_is(s_axi_araddr_i, i2iv_pkg::ADDR_MASTER_CONTROL)) begin
        s_axi_rdata_o <= ctl_word;
        s_axi_rresp_o <= i2iv_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata_o <= i2iv_pkg::ZERO_WORD;
        s_axi_rresp_o <= i2iv_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'h0;
    end
  end

  // ---------------- Link clock domain ----------------
  logic      link_rst_meta;
  logic      link_rst;
  logic      dma_meta;
  logic      dma_sync;
  logic      link_cmd_valid;
  i2iv_pkg::i2iv_cmd_t link_cmd;

  // Reset reaches the link side through two stages; it is held long enough
  // only if the link clock runs while rst_i is high.
  always_ff @(posedge link_clock_i) begin
    link_rst_meta <= rst_i;
    link_rst      <= link_rst_meta;
  end

  always_ff @(posedge link_clock_i) begin
    if (link_rst) begin
      dma_meta <= 1'h0;
      dma_sync <= 1'h0;
    end else begin
      dma_meta <= dma_enable_o;
      dma_sync <= dma_meta;
    end
  end

  i2iv_cmd_cross u_cmd_cross (
    .src_clock_i (clock_i),
    .src_rst_i   (rst_i),
    .src_valid_i (cmd_launch),
    .src_cmd_i   (cmd_pend),
    .src_busy_o  (cmd_busy),
    .dst_clock_i (link_clock_i),
    .dst_rst_i   (link_rst),
    .dst_valid_o (link_cmd_valid),
    .dst_cmd_o   (link_cmd)
  );

  // One link-clock pulse per command; the master timing decides when the
  // condition actually appears on the bus
  always_ff @(posedge link_clock_i) begin
    if (link_rst) begin
      link_proceed_o  <= 1'h0;
      link_begin_o    <= 1'h0;
      link_end_o      <= 1'h0;
      link_end_nack_o <= 1'h0;
    end else begin
      link_proceed_o  <= link_cmd_valid && link_cmd.master_proceed;
      link_begin_o    <= link_cmd_valid && link_cmd.master_begin_cmd;
      link_end_o      <= link_cmd_valid && link_cmd.master_end_cmd;
      link_end_nack_o <= link_cmd_valid && link_cmd.master_end_cmd
                         && link_receiving_i;
    end
  end

  // No pending flag is produced here when a DMA run ends; the request
  // simply drops with the data phase
  always_ff @(posedge link_clock_i) begin
    if (link_rst) begin
      link_dma_req_o  <= 1'h0;
      link_auto_ack_o <= 1'h0;
    end else begin
      link_dma_req_o  <= dma_sync && link_data_phase_i;
      link_auto_ack_o <= dma_sync && link_receiving_i;
    end
  end

endmodule : i2iv_view_ctl
`default_nettype wire

// ==== verification/i2iv_link_model.sv ====
// Far-side model: bus master state seen by the link logic
`timescale 1ns/1ns
`default_nettype none
module i2iv_link_model (
  input  wire logic link_clock_i,
  input  wire logic recv_i,
  input  wire logic data_i,
  output logic      link_receiving_o,
  output logic      link_data_phase_o
);
  // Modes change only on the link clock, as the real master state does
  always_ff @(posedge link_clock_i) begin
    link_receiving_o  <= recv_i;
    link_data_phase_o <= data_i;
  end
endmodule : i2iv_link_model
`default_nettype wire

// ==== verification/i2iv_checker.sv ====
// Assertions on the ports of the view and control block
`timescale 1ns/1ns
`default_nettype none
module i2iv_checker (
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire logic [11:0]           s_axi_araddr_i,
  input wire logic                  s_axi_arvalid_i,
  input wire logic                  s_axi_arready_o,
  input wire logic [31:0]           s_axi_rdata_o,
  input wire logic                  s_axi_rvalid_o,
  input wire logic                  s_axi_rready_i,
  input wire logic                  s_axi_bvalid_o,
  input wire i2iv_pkg::i2iv_flags_t status_raw_i,
  input wire i2iv_pkg::i2iv_flags_t int_enable_i,
  input wire logic                  dma_enable_o,
  input wire logic                  link_clock_i,
  input wire logic                  link_receiving_i,
  input wire logic                  link_proceed_o,
  input wire logic                  link_begin_o,
  input wire logic                  link_end_o,
  input wire logic                  link_end_nack_o,
  input wire logic                  link_auto_ack_o
);
  function automatic logic [31:0] vw(input logic [10:0] f);
    vw = {6'h0, f[0], f[1], 4'h0, f[2], 1'h0, f[3], f[4], f[5], 3'h0, f[6], 2'h0, f[7],
          1'h0, f[8], 1'h0, f[9], 3'h0, f[10]};
  endfunction : vw

  a_view_read: assert property (@(posedge clock_i) disable iff (rst_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 12'h818
    |=> s_axi_rdata_o == vw($past(status_raw_i) & $past(int_enable_i)))
    else $error("view read data wrong");
  a_ctl_read: assert property (@(posedge clock_i) disable iff (rst_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 12'h820
    |=> s_axi_rdata_o == {28'h0, $past(dma_enable_o), 3'h0})
    else $error("control read data wrong");
  a_dma_cause: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(dma_enable_o) |-> $rose(s_axi_bvalid_o))
    else $error("dma enable moved without a write");
  a_reset_clean: assert property (@(posedge clock_i)
    rst_i |=> !s_axi_rvalid_o && !s_axi_bvalid_o && !dma_enable_o)
    else $error("outputs not cleared by reset");
  a_end_nack: assert property (@(posedge link_clock_i) disable iff (rst_i)
    link_end_o |-> link_end_nack_o == $past(link_receiving_i))
    else $error("stop nack does not follow receive mode");
  a_nack_alone: assert property (@(posedge link_clock_i) disable iff (rst_i)
    link_end_nack_o |-> link_end_o)
    else $error("nack without stop");
  a_pulse_once: assert property (@(posedge link_clock_i) disable iff (rst_i)
    (link_proceed_o || link_begin_o || link_end_o)
    |=> !(link_proceed_o || link_begin_o || link_end_o))
    else $error("command pulse longer than one link cycle");
  a_auto_ack: assert property (@(posedge link_clock_i) disable iff (rst_i)
    link_auto_ack_o |-> $past(link_receiving_i))
    else $error("auto acknowledge outside receive mode");

  c_view: cover property (@(posedge clock_i) s_axi_rvalid_o && s_axi_rready_i);
  c_nack: cover property (@(posedge link_clock_i) link_end_nack_o);
  c_ack: cover property (@(posedge link_clock_i) $rose(link_auto_ack_o));
endmodule : i2iv_checker

bind i2iv_view_ctl i2iv_checker chk_u (.clock_i(clock_i), .rst_i(rst_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_bvalid_o(s_axi_bvalid_o), .status_raw_i(status_raw_i), .int_enable_i(int_enable_i),
  .dma_enable_o(dma_enable_o), .link_clock_i(link_clock_i), .link_receiving_i(link_receiving_i),
  .link_proceed_o(link_proceed_o), .link_begin_o(link_begin_o), .link_end_o(link_end_o),
  .link_end_nack_o(link_end_nack_o), .link_auto_ack_o(link_auto_ack_o));
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the interrupt view and master control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                  clock_i = 1'h0;
  logic                  lclk    = 1'h0;
  logic                  rst_i   = 1'h1;
  logic [11:0]           awaddr  = 12'h0, araddr = 12'h0;
  logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                  arvalid = 1'h0, rready = 1'h0, recv = 1'h0, dph = 1'h0;
  logic [31:0]           wdata   = 32'h0, rdata;
  logic [3:0]            wstrb   = 4'hF, c;
  logic [1:0]            bresp, rresp;
  logic                  awready, wready, bvalid, arready, rvalid, dma, busy;
  logic                  lrecv, ldph, lp, lb, le, ln, ldr, laa;
  i2iv_pkg::i2iv_flags_t raw = '0, en = '0;
  logic [33:0]           bq[$];
  logic [3:0]            lq[$];
  logic [3:0]            cmds[6] = '{4'h9, 4'h2, 4'h4, 4'h7, 4'h0, 4'h8};
  int                    failures = 0, n_checks = 0, i, j;

  always #4 clock_i = ~clock_i;
  always #40 lclk = ~lclk;

  i2iv_view_ctl dut_u (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .status_raw_i(raw), .int_enable_i(en), .dma_enable_o(dma),
    .cmd_in_flight_o(busy), .link_clock_i(lclk), .link_receiving_i(lrecv),
    .link_data_phase_i(ldph), .link_proceed_o(lp), .link_begin_o(lb), .link_end_o(le),
    .link_end_nack_o(ln), .link_dma_req_o(ldr), .link_auto_ack_o(laa));
  i2iv_link_model model_u (.link_clock_i(lclk), .recv_i(recv), .data_i(dph),
    .link_receiving_o(lrecv), .link_data_phase_o(ldph));

  function automatic logic [31:0] vw(input logic [10:0] f);
    vw = {6'h0, f[0], f[1], 4'h0, f[2], 1'h0, f[3], f[4], f[5], 3'h0, f[6], 2'h0, f[7],
          1'h0, f[8], 1'h0, f[9], 3'h0, f[10]};
  endfunction : vw

  task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // One access at a time; the expected answer is queued for the monitor
  task automatic bus(input bit rd, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int t;
    bq.push_back(e);
    @(posedge clock_i);
    if (rd) begin
      arvalid <= 1'h1;
      araddr  <= a;
      rready  <= 1'h1;
    end else begin
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      awaddr  <= a;
      wdata   <= d;
      bready  <= 1'h1;
    end
    for (t = 0; t < 100; t++) begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'h0;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if ((rvalid && rready) || (bvalid && bready)) break;
    end
    rready <= 1'h0;
    bready <= 1'h0;
  endtask : bus

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  always @(posedge clock_i) begin
    if (rvalid && rready) check("read", {rresp, rdata}, bq.pop_front());
    if (bvalid && bready) check("bresp", {bresp, 32'h0}, bq.pop_front());
  end

  always @(posedge lclk) begin
    if ((lp | lb | le) === 1'h1) check("link_cmd", {ln, le, lb, lp}, lq.pop_front());
  end

  initial begin
    #200000;
    failures++;
    wrap_up;
  end

  initial begin
    void'($urandom(32'hEAF0));
    repeat (10) @(posedge clock_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge lclk);
    bus(1, 12'h820, 0, 34'h0);
    for (i = 0; i < 11; i++) begin
      @(posedge clock_i);
      raw <= 11'h1 << i;
      en  <= 11'h7FF;
      bus(1, 12'h818, 0, {2'h0, vw(11'h1 << i)});
      @(posedge clock_i);
      raw <= 11'h7FF;
      en  <= ~(11'h1 << i);
      bus(1, 12'h818, 0, {2'h0, vw(~(11'h1 << i))});
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clock_i);
      raw <= 11'($urandom);
      en  <= 11'($urandom);
      bus(0, 12'h818, $urandom & 32'h030B8951, 34'h0);
      bus(1, 12'h818, 0, {2'h0, vw(raw & en)});
    end
    bus(1, 12'h81C, 0, {i2iv_pkg::RESP_SLVERR, 32'h0});
    bus(0, 12'h81C, 0, {i2iv_pkg::RESP_SLVERR, 32'h0});
    $display("test view done");
    // Receive mode from entry 2 on, so stops there carry a nack
    for (i = 0; i < 6; i++) begin
      c = cmds[i];
      @(posedge clock_i);
      raw  <= i2iv_pkg::i2iv_flags_t'(11'h400);
      recv <= (i > 1);
      dph  <= i[0];
      repeat (3) @(posedge lclk);
      if (c[2:0] != 3'h0) lq.push_back({c[2] & (i > 1), c[2:0]});
      bus(0, 12'h820, {28'h0, c}, 34'h0);
      for (j = 0; j < 300 && busy !== 1'h0; j++) @(posedge clock_i);
      check("cmd_idle", busy, 1'h0);
      repeat (4) @(posedge lclk);
      check("dma", dma, c[3]);
      check("dma_req", ldr, c[3] & i[0]);
      check("auto_ack", laa, c[3] & (i > 1));
      bus(1, 12'h820, 0, {30'h0, c[3], 3'h0});
    end
    @(posedge clock_i);
    wstrb <= 4'hE;
    bus(0, 12'h820, 32'h0000_0007, 34'h0);
    repeat (8) @(posedge lclk);
    bus(1, 12'h820, 0, {30'h0, 1'h1, 3'h0});
    check("link_left", lq.size(), 0);
    $display("test control done");
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
